/* File: hw/fcq_freq_calib_phase_qualify.sv */
// Purpose: frequency calibration against an external reference and phase output qualification
// Assumes: register requests arrive already decoded from the serial interface; reference
//          pin is synchronous to clk
// Notes: measured value = 4000h * expected / observed system clocks per reference period
//
// Behaviour
// - bit 23 of the control register turns frequency correction of the phase output on or off.
// - bit 22 enables the calibration block, and clearing it stops any measurement.
// - bit 21 chooses the trimmed value (0) or the measured value (1) for correction.
// - the 15-bit reference count limit, reset 4C4Bh, gives divided ticks per reference period.
// - writing 1 to bit 16 starts one calibration measurement.
// - with continuous calibration set the block measures again and again, else only on start.
// - a read-only 15-bit field, reset 4000h, holds the measured correction value.
// - a read-only 15-bit field presents the trimmed correction value.
// - a 16-bit amplitude threshold split over two registers forces phase to FFFFh below it.
// - with overload gating enabled the phase output is gated while the overload flag is 1.
`timescale 1ns/1ps

module fcq_freq_calib_phase_qualify #(
   parameter int VALUE_W = 15
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // register access from the serial interface
   input wire logic regWrite,
   input wire logic regRead,
   input wire fcq_pkg::fcq_reg_req_s regReq,
   output logic [23:0] regRdata,
   // trim and reference
   input wire logic [VALUE_W-1:0] trimmedFreqValue,
   input wire logic referenceClockPin,
   // depth samples in
   input wire logic sampleValid,
   input wire fcq_pkg::fcq_sample_s sampleIn,
   // qualified phase out and calibration busy
   output logic phaseOutValid,
   output logic [15:0] phaseOut,
   output logic calibBusy
);

   // ==========================================================
   // reset synchroniser
   logic rstMeta;
   logic rstSync;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   logic rstN;
   assign rstN = rstSync;

   // ==========================================================
   // registers
   logic phaseFreqCorrectEnable;
   logic calibBlockEnable;
   logic correctionSourceSelect;
   logic [3:0] sysclkDivideExponent;
   logic calibStart;
   logic [14:0] refCountLimit;
   logic [15:0] minAmplitudeThreshold;
   logic continuousCalibEnable;
   logic overloadGateDisable;
   logic [15:0] seqCompareThresholdOne;
   logic [2:0] comparatorInputSelect;
   logic [VALUE_W-1:0] measuredFreqValue;
   logic calibDone;

   logic wrCtrl;
   assign wrCtrl = regWrite && regReq.addr == fcq_pkg::ADDR_FREQ_CALIB_CONTROL;

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         phaseFreqCorrectEnable <= 1'b0;
         calibBlockEnable <= 1'b0;
         correctionSourceSelect <= 1'b0;
         sysclkDivideExponent <= fcq_pkg::RST_DIVIDE_EXP;
         refCountLimit <= fcq_pkg::RST_REF_COUNT_LIMIT;
      end else if (ce && wrCtrl) begin
         phaseFreqCorrectEnable <= regReq.data[fcq_pkg::POS_PHASE_FREQ_CORRECT_ENABLE];
         calibBlockEnable <= regReq.data[fcq_pkg::POS_CALIB_BLOCK_ENABLE];
         correctionSourceSelect <= regReq.data[fcq_pkg::POS_CORRECTION_SOURCE_SELECT];
         sysclkDivideExponent <=
            regReq.data[fcq_pkg::POS_DIVIDE_EXP_HI:fcq_pkg::POS_DIVIDE_EXP_LO];
         refCountLimit <= regReq.data[fcq_pkg::POS_VALUE_HI:0];
      end
   end

   // start stays set until the measurement it launched is done or the block is disabled; any control write reloads it from bit 16 and wins
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         calibStart <= 1'b0;
      end else if (ce) begin
         if (wrCtrl) begin
            calibStart <= regReq.data[fcq_pkg::POS_CALIB_START];
         end else if (calibDone || !calibBlockEnable) begin
            calibStart <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         minAmplitudeThreshold <= 16'h0000;
         continuousCalibEnable <= 1'b0;
         overloadGateDisable <= 1'b0;
         seqCompareThresholdOne <= 16'h0000;
         comparatorInputSelect <= 3'h0;
      end else if (ce && regWrite) begin
         case (regReq.addr)
            fcq_pkg::ADDR_AMP_THR_HIGH_MEAS: begin
               minAmplitudeThreshold[15:8] <=
                  regReq.data[fcq_pkg::POS_THR_BYTE_HI:fcq_pkg::POS_THR_BYTE_LO];
               continuousCalibEnable <= regReq.data[fcq_pkg::POS_FLAG15];
            end
            fcq_pkg::ADDR_AMP_THR_LOW_TRIM: begin
               minAmplitudeThreshold[7:0] <=
                  regReq.data[fcq_pkg::POS_THR_BYTE_HI:fcq_pkg::POS_THR_BYTE_LO];
               overloadGateDisable <= regReq.data[fcq_pkg::POS_FLAG15];
            end
            fcq_pkg::ADDR_SEQ_COMPARE_ONE: begin
               seqCompareThresholdOne <=
                  regReq.data[fcq_pkg::POS_CMP_ONE_HI:fcq_pkg::POS_CMP_ONE_LO];
               comparatorInputSelect <= regReq.data[fcq_pkg::POS_MUX_SEL_HI:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // read path, registered; unmapped indices read zero
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         regRdata <= 24'h000000;
      end else if (ce && regRead) begin
         case (regReq.addr)
            fcq_pkg::ADDR_FREQ_CALIB_CONTROL:
               regRdata <= {phaseFreqCorrectEnable, calibBlockEnable, correctionSourceSelect,
                            sysclkDivideExponent, calibStart, 1'b0, refCountLimit};
            fcq_pkg::ADDR_AMP_THR_HIGH_MEAS:
               regRdata <= {minAmplitudeThreshold[15:8], continuousCalibEnable,
                            measuredFreqValue};
            fcq_pkg::ADDR_AMP_THR_LOW_TRIM:
               regRdata <= {minAmplitudeThreshold[7:0], overloadGateDisable,
                            trimmedFreqValue};
            fcq_pkg::ADDR_SEQ_COMPARE_ONE:
               regRdata <= {5'h00, seqCompareThresholdOne, comparatorInputSelect};
            default:
               regRdata <= 24'h000000;
         endcase
      end
   end

   // ==========================================================
   // calibration: count system clocks over one reference period, then divide
   fcq_pkg::fcq_cal_state_e calState;
   logic refPrev;
   logic refRise;
   logic [fcq_pkg::PERIOD_CNT_BITS-1:0] periodCount;
   logic [fcq_pkg::DIV_NUM_BITS-1:0] divNum;
   logic [fcq_pkg::DIV_NUM_BITS-1:0] divQuot;
   logic [fcq_pkg::PERIOD_CNT_BITS:0] divRem;
   logic [5:0] divStep;
   logic wantMeasure;
   logic [fcq_pkg::PERIOD_CNT_BITS:0] next_divRem;

   assign refRise = referenceClockPin && !refPrev;
   // start is still set in the cycle after the last divide step; that must not launch a rerun
   assign wantMeasure = (calibStart && !calibDone) || continuousCalibEnable;
   assign next_divRem = {divRem[fcq_pkg::PERIOD_CNT_BITS-1:0],
                         divNum[fcq_pkg::DIV_NUM_BITS-1]};
   assign calibBusy = calState != fcq_pkg::CAL_IDLE;

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         refPrev <= 1'b0;
      end else if (ce) begin
         refPrev <= referenceClockPin;
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         calState <= fcq_pkg::CAL_IDLE;
         periodCount <= '0;
         divNum <= '0;
         divQuot <= '0;
         divRem <= '0;
         divStep <= 6'h00;
         calibDone <= 1'b0;
      end else if (ce) begin
         calibDone <= 1'b0;
         if (!calibBlockEnable) begin
            calState <= fcq_pkg::CAL_IDLE;
         end else begin
            case (calState)
               fcq_pkg::CAL_IDLE: begin
                  if (wantMeasure) begin
                     calState <= fcq_pkg::CAL_WAIT_EDGE;
                  end
               end
               fcq_pkg::CAL_WAIT_EDGE: begin
                  periodCount <= 32'h00000001;
                  if (refRise) begin
                     calState <= fcq_pkg::CAL_COUNT;
                  end
               end
               fcq_pkg::CAL_COUNT: begin
                  if (refRise) begin
                     // expected clocks per period = limit << exponent
                     divNum <= fcq_pkg::DIV_NUM_BITS'({29'h0, refCountLimit}) <<
                               (5'(sysclkDivideExponent) + 5'(fcq_pkg::CORR_FRAC_BITS));
                     divQuot <= '0;
                     divRem <= '0;
                     divStep <= 6'h00;
                     calState <= fcq_pkg::CAL_DIVIDE;
                  end else if (periodCount != 32'hFFFFFFFF) begin
                     periodCount <= periodCount + 32'h00000001;
                  end
               end
               fcq_pkg::CAL_DIVIDE: begin
                  divNum <= {divNum[fcq_pkg::DIV_NUM_BITS-2:0], 1'b0};
                  if (next_divRem >= {1'b0, periodCount}) begin
                     divRem <= next_divRem - {1'b0, periodCount};
                     divQuot <= {divQuot[fcq_pkg::DIV_NUM_BITS-2:0], 1'b1};
                  end else begin
                     divRem <= next_divRem;
                     divQuot <= {divQuot[fcq_pkg::DIV_NUM_BITS-2:0], 1'b0};
                  end
                  divStep <= divStep + 6'h01;
                  if (divStep == 6'(fcq_pkg::DIV_NUM_BITS - 1)) begin
                     calibDone <= 1'b1;
                     calState <= fcq_pkg::CAL_IDLE;
                  end
               end
               default: calState <= fcq_pkg::CAL_IDLE;
            endcase
         end
      end
   end

   // quotient is taken one cycle after the last step; saturates to the field width
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         measuredFreqValue <= fcq_pkg::RST_MEASURED_FREQ;
      end else if (ce && calibDone) begin
         if (divQuot > fcq_pkg::DIV_NUM_BITS'(fcq_pkg::CORR_MAX)) begin
            measuredFreqValue <= fcq_pkg::CORR_MAX;
         end else begin
            measuredFreqValue <= divQuot[VALUE_W-1:0];
         end
      end
   end

   // ==========================================================
   // phase qualification
   logic [VALUE_W-1:0] corrValue;
   logic [15+VALUE_W:0] corrProduct;
   logic [15:0] correctedPhase;

   assign corrValue = correctionSourceSelect ? measuredFreqValue : trimmedFreqValue;
   assign corrProduct = {{VALUE_W{1'b0}}, sampleIn.phase} * {16'h0000, corrValue};

   // saturate rather than wrap: a wrapped phase would alias to a near distance
   always_comb begin
      if (corrProduct[15+VALUE_W:fcq_pkg::CORR_FRAC_BITS] > 32'(16'hFFFF)) begin
         correctedPhase = 16'hFFFE;
      end else begin
         correctedPhase = corrProduct[fcq_pkg::CORR_FRAC_BITS+15:fcq_pkg::CORR_FRAC_BITS];
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         phaseOut <= 16'h0000;
         phaseOutValid <= 1'b0;
      end else if (ce) begin
         phaseOutValid <= sampleValid &&
                          (overloadGateDisable || !sampleIn.overload);
         if (sampleValid) begin
            if (sampleIn.amplitude < minAmplitudeThreshold) begin
               phaseOut <= fcq_pkg::PHASE_INVALID;
            end else if (phaseFreqCorrectEnable) begin
               phaseOut <= correctedPhase;
            end else begin
               phaseOut <= sampleIn.phase;
            end
         end
      end
   end

endmodule

/* File: hw/fcq_pkg.sv */
// Purpose: constants and carrier types for the frequency calibration and phase qualify block
// Assumes: 24-bit registers at byte-wide register indices
// Notes: every offset, field position and non-zero reset value lives here
package fcq_pkg;

   // ==========================================================
   // register map
   localparam logic [7:0] ADDR_FREQ_CALIB_CONTROL = 8'h0F;
   localparam logic [7:0] ADDR_AMP_THR_HIGH_MEAS = 8'h10;
   localparam logic [7:0] ADDR_AMP_THR_LOW_TRIM = 8'h11;
   localparam logic [7:0] ADDR_SEQ_COMPARE_ONE = 8'h13;

   // ==========================================================
   // field positions, control register
   localparam int POS_PHASE_FREQ_CORRECT_ENABLE = 23;
   localparam int POS_CALIB_BLOCK_ENABLE = 22;
   localparam int POS_CORRECTION_SOURCE_SELECT = 21;
   localparam int POS_DIVIDE_EXP_HI = 20;
   localparam int POS_DIVIDE_EXP_LO = 17;
   localparam int POS_CALIB_START = 16;
   localparam int POS_CTRL_RESERVED = 15;
   localparam int POS_VALUE_HI = 14;
   // threshold byte of either amplitude register (high half at 10h, low half at 11h) and the shared bit 15 flags
   localparam int POS_THR_BYTE_HI = 23;
   localparam int POS_THR_BYTE_LO = 16;
   localparam int POS_FLAG15 = 15;
   // sequencer compare register
   localparam int POS_CMP_ONE_HI = 18;
   localparam int POS_CMP_ONE_LO = 3;
   localparam int POS_MUX_SEL_HI = 2;

   // ==========================================================
   // reset values and the forced invalid phase
   localparam logic [3:0] RST_DIVIDE_EXP = 4'hA;
   localparam logic [14:0] RST_REF_COUNT_LIMIT = 15'h4C4B;
   localparam logic [14:0] RST_MEASURED_FREQ = 15'h4000;
   localparam logic [15:0] PHASE_INVALID = 16'hFFFF;
   // unity gain of the correction value
   localparam int CORR_FRAC_BITS = 14;
   localparam logic [14:0] CORR_MAX = 15'h7FFF;

   // ==========================================================
   // timing
   localparam int CLK_FREQ_HZ = 40000000;
   localparam int DIV_NUM_BITS = 44;
   localparam int PERIOD_CNT_BITS = 32;

   typedef enum logic [2:0] {
      CAL_IDLE,
      CAL_WAIT_EDGE,
      CAL_COUNT,
      CAL_DIVIDE
   } fcq_cal_state_e;

   // register read or write request as handed over by the serial interface
   typedef struct packed {
      logic [7:0] addr;
      logic [23:0] data;
   } fcq_reg_req_s;

   // one depth sample
   typedef struct packed {
      logic [15:0] phase;
      logic [15:0] amplitude;
      logic overload;
   } fcq_sample_s;

endpackage

/* File: dv/fcq_freq_calib_phase_qualify_assertions.sv */
// Purpose: port-level checks of fcq_freq_calib_phase_qualify
// Assumes: registers change only through regWrite with ce high
// Notes: keeps a shadow of the threshold and the phase-path flags
`timescale 1ns/1ps
module fcq_chk #(
   parameter int VALUE_W = 15
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // register port
   input wire logic regWrite,
   input wire logic regRead,
   input wire fcq_pkg::fcq_reg_req_s regReq,
   input wire logic [23:0] regRdata,
   // trim and reference
   input wire logic [VALUE_W-1:0] trimmedFreqValue,
   input wire logic referenceClockPin,
   // phase path and calibration busy
   input wire logic sampleValid,
   input wire fcq_pkg::fcq_sample_s sampleIn,
   input wire logic phaseOutValid,
   input wire logic [15:0] phaseOut,
   input wire logic calibBusy
);
   logic [15:0] thr;
   logic gateDis;
   logic corrEn;
   logic wr;
   logic take;
   assign wr = ce && regWrite;
   assign take = ce && sampleValid;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // ==========================================================
   // shadow of the writable fields that steer the phase path
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         thr <= 16'h0;
         gateDis <= 1'b0;
         corrEn <= 1'b0;
      end else if (wr) begin
         if (regReq.addr == 8'h0F) corrEn <= regReq.data[23];
         if (regReq.addr == 8'h10) thr[15:8] <= regReq.data[23:16];
         if (regReq.addr == 8'h11) thr[7:0] <= regReq.data[23:16];
         if (regReq.addr == 8'h11) gateDis <= regReq.data[15];
      end
   end
   // ==========================================================
   // assertions
   chk_amp_forced: assert property (take && sampleIn.amplitude < thr |=>
      phaseOut == 16'hFFFF) else $error("phase not forced below threshold");
   chk_amp_unsigned: assert property (take && !corrEn && sampleIn.amplitude >= thr |=>
      phaseOut == $past(sampleIn.phase)) else $error("phase changed at or above threshold");
   chk_ovl_gated: assert property (take && sampleIn.overload && !gateDis |=>
      !phaseOutValid) else $error("overloaded sample not gated");
   chk_ovl_passed: assert property (take && (!sampleIn.overload || gateDis) |=>
      phaseOutValid) else $error("sample lost");
   chk_valid_cause: assert property (phaseOutValid |-> $past(take))
      else $error("valid without sample");
   chk_phase_hold: assert property (!$past(take) |-> $stable(phaseOut))
      else $error("phase moved without sample");
   chk_reserved_zero: assert property (ce && regRead && regReq.addr == 8'h0F |=> !regRdata[15])
      else $error("reserved bit read as one");
   chk_trim_read: assert property (ce && regRead && regReq.addr == 8'h11 |=>
      regRdata[14:0] == $past(trimmedFreqValue)) else $error("trim field wrong");
   chk_start_busy: assert property (wr && regReq.addr == 8'h0F && regReq.data[22]
      && regReq.data[16] |-> ##2 calibBusy) else $error("start did not begin calibration");
   chk_disable_idle: assert property (wr && regReq.addr == 8'h0F && !regReq.data[22]
      |-> ##2 !calibBusy) else $error("disable did not stop calibration");
   cov_calib_done: cover property ($fell(calibBusy));
   cov_gated: cover property (take && sampleIn.overload && !gateDis);
   cov_forced: cover property (take && sampleIn.amplitude < thr);
endmodule
bind fcq_freq_calib_phase_qualify fcq_chk #(.VALUE_W(VALUE_W)) chk_u (.clk(clk), .nrst(nrst),
   .ce(ce), .regWrite(regWrite), .regRead(regRead), .regReq(regReq), .regRdata(regRdata),
   .trimmedFreqValue(trimmedFreqValue), .referenceClockPin(referenceClockPin),
   .sampleValid(sampleValid), .sampleIn(sampleIn), .phaseOutValid(phaseOutValid),
   .phaseOut(phaseOut), .calibBusy(calibBusy));

/* File: dv/fcq_ref_source.sv */
// Purpose: external reference clock on the reference pin
// Assumes: the pin is synchronous to clk
// Notes: the pin rests low while not running, so no stray edge is seen
`timescale 1ns/1ps
module fcq_ref_source #(
   parameter int PERIOD = 64
) (
   // clock and control
   input wire logic clk,
   input wire logic run,
   // reference pin
   output logic referenceClockPin
);
   int cnt = 0;
   always @(posedge clk) begin
      cnt <= run ? (cnt + 1) % PERIOD : 0;
   end
   assign referenceClockPin = run && cnt < PERIOD / 2;
endmodule

/* File: dv/fcq_freq_calib_phase_qualify_bench.sv */
// Purpose: self-checking bench of fcq_freq_calib_phase_qualify
// Assumes: reference period of 64 clocks
// Notes: expected calibration value worked out from limit, exponent and period
`timescale 1ns/1ps
module fcq_freq_calib_phase_qualify_bench;
   logic clk;
   logic nrst;
   logic ceIn;
   logic regWrite;
   logic regRead;
   fcq_pkg::fcq_reg_req_s regReq;
   logic [23:0] regRdata;
   logic [14:0] trimValue;
   logic refPin;
   logic refRun;
   logic sampleValid;
   fcq_pkg::fcq_sample_s sampleIn;
   logic phaseOutValid;
   logic [15:0] phaseOut;
   logic calibBusy;
   int num_errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   fcq_freq_calib_phase_qualify dut_u (.clk(clk), .nrst(nrst), .ce(ceIn), .regWrite(regWrite),
      .regRead(regRead), .regReq(regReq), .regRdata(regRdata), .trimmedFreqValue(trimValue),
      .referenceClockPin(refPin), .sampleValid(sampleValid), .sampleIn(sampleIn),
      .phaseOutValid(phaseOutValid), .phaseOut(phaseOut), .calibBusy(calibBusy));
   fcq_ref_source #(.PERIOD(64)) ref_u (.clk(clk), .run(refRun), .referenceClockPin(refPin));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ==========================================================
   // shared tasks
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [23:0] d);
      @(negedge clk);
      regWrite = 1'b1;
      regReq = '{addr: a, data: d};
      @(negedge clk);
      regWrite = 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [23:0] exp);
      @(negedge clk);
      regRead = 1'b1;
      regReq.addr = a;
      @(negedge clk);
      regRead = 1'b0;
      @(negedge clk);
      chk(regRdata, exp);
   endtask
   task automatic smp(input logic [15:0] ph, input logic [15:0] amp, input logic ovl,
         input logic expV, input logic [15:0] expP);
      @(negedge clk);
      sampleValid = 1'b1;
      sampleIn = '{phase: ph, amplitude: amp, overload: ovl};
      @(negedge clk);
      sampleValid = 1'b0;
      chk({23'h0, phaseOutValid}, {23'h0, expV});
      chk({8'h0, phaseOut}, {8'h0, expP});
   endtask
   // a bounded wait, so a stuck calibration shows as a mismatch
   task automatic waitBusy(input logic lvl);
      int n;
      n = 0;
      while (calibBusy !== lvl && n < 400) begin
         @(negedge clk);
         n++;
      end
      chk({23'h0, calibBusy}, {23'h0, lvl});
   endtask
   // ==========================================================
   // scenarios
   task automatic t_regs();
      rdc(8'h0F, 24'h144C4B);
      rdc(8'h10, 24'h004000);
      wr(8'h0F, 24'h1A4C4B);
      rdc(8'h0F, 24'h1A4C4B);
      wr(8'h10, 24'h007FFF);
      rdc(8'h10, 24'h004000);
      wr(8'h11, 24'h001234);
      rdc(8'h11, 24'h006000);
      wr(8'h13, 24'h07FFFF);
      rdc(8'h13, 24'h07FFFF);
      rdc(8'h12, 24'h000000);
      $display("test registers done");
   endtask
   task automatic t_thr();
      wr(8'h10, 24'h120000);
      wr(8'h11, 24'h340000);
      smp(16'h0ABC, 16'h1233, 1'b0, 1'b1, 16'hFFFF);
      smp(16'h0ABC, 16'h1234, 1'b0, 1'b1, 16'h0ABC);
      smp(16'h0ABD, 16'h8000, 1'b0, 1'b1, 16'h0ABD);
      smp(16'h0ABE, 16'h0000, 1'b0, 1'b1, 16'hFFFF);
      $display("test threshold done");
   endtask
   task automatic t_ovl();
      smp(16'h0100, 16'hFFFF, 1'b1, 1'b0, 16'h0100);
      wr(8'h11, 24'h348000);
      rdc(8'h11, 24'h34E000);
      smp(16'h0101, 16'hFFFF, 1'b1, 1'b1, 16'h0101);
      wr(8'h11, 24'h340000);
      $display("test overload done");
   endtask
   task automatic t_calib();
      refRun = 1'b1;
      wr(8'h0F, 24'h430010);
      waitBusy(1'b1);
      waitBusy(1'b0);
      repeat (2) @(negedge clk);
      rdc(8'h10, 24'h122000);
      rdc(8'h0F, 24'h420010);
      repeat (100) @(negedge clk);
      chk({23'h0, calibBusy}, 24'h0);
      $display("test calibration done");
   endtask
   task automatic t_corr();
      wr(8'h0F, 24'hA20010);
      smp(16'h1000, 16'hFFFF, 1'b0, 1'b1, 16'h0800);
      wr(8'h0F, 24'h820010);
      smp(16'h1000, 16'hFFFF, 1'b0, 1'b1, 16'h1800);
      smp(16'hF000, 16'hFFFF, 1'b0, 1'b1, 16'hFFFE);
      wr(8'h0F, 24'h020010);
      smp(16'hF000, 16'hFFFF, 1'b0, 1'b1, 16'hF000);
      $display("test correction done");
   endtask
   // ce low must freeze the register file and the phase path
   task automatic t_freeze();
      @(negedge clk);
      ceIn = 1'b0;
      wr(8'h10, 24'hFF8000);
      smp(16'h0200, 16'h0000, 1'b0, 1'b0, 16'hF000);
      ceIn = 1'b1;
      rdc(8'h10, 24'h122000);
      $display("test clock enable done");
   endtask
   task automatic t_cont();
      wr(8'h10, 24'h128000);
      wr(8'h0F, 24'h420010);
      waitBusy(1'b1);
      waitBusy(1'b0);
      repeat (3) @(negedge clk);
      chk({23'h0, calibBusy}, 24'h1);
      wr(8'h0F, 24'h020010);
      @(negedge clk);
      chk({23'h0, calibBusy}, 24'h0);
      wr(8'h10, 24'h120000);
      refRun = 1'b0;
      $display("test continuous done");
   endtask
   // ==========================================================
   // main sequence and hang guard
   initial begin
      nrst = 1'b0;
      ceIn = 1'b1;
      regWrite = 1'b0;
      regRead = 1'b0;
      regReq = '0;
      trimValue = 15'h6000;
      refRun = 1'b0;
      sampleValid = 1'b0;
      sampleIn = '0;
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      t_regs();
      t_thr();
      t_ovl();
      t_calib();
      t_corr();
      t_freeze();
      t_cont();
      wrap_up();
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         wrap_up();
      end
   end
endmodule
